// ==== fsb_req_params.svh ====
// Purpose: shared constants of the request-phase address logic
// Assumes: pin levels are active low on the wire unless named otherwise
// Notes:   definitions only, included by the package and the ends
`ifndef FSB_REQ_PARAMS_SVH
`define FSB_REQ_PARAMS_SVH

// ------------------------------------------------------------------
// address and request line fields
// ------------------------------------------------------------------
`define ADDR_MSB      35
`define ADDR_LSB      3
`define REQ_MSB       4
`define LO_GRP_MSB    16
`define HI_GRP_LSB    17
`define HI_PAR_LSB    24
`define LO_PAR_MSB    23
`define BIT20_POS     20

// ------------------------------------------------------------------
// idle pin levels
// ------------------------------------------------------------------
`define ADDR_IDLE     33'h1_ffff_ffff
`define REQ_IDLE      5'h1f
`define STB_IDLE      2'h3
`define STB_ACTIVE    2'h0
`define PAR_IDLE      2'h3

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
// strobe edge follows the data change by this many clk_sys cycles plus one
`define STB_DLY_NS    10
`define SYS_PERIOD_NS 5
`define STB_DLY_CYC   (`STB_DLY_NS / `SYS_PERIOD_NS)

`endif

// ==== fsb_req_pkg.sv ====
// Purpose: types and helpers shared by both ends of the request phase
// Assumes: fsb_req_params.svh on the include path
// Notes:   parity helper works on asserted-high (logical) values
`include "fsb_req_params.svh"

package fsb_req_pkg;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef logic [`ADDR_MSB:`ADDR_LSB] addr_t;
  typedef logic [`REQ_MSB:0]          req_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SUB1,
    PH_SUB2
  } phase_state_t;

  // one sample of every observed pin, wire levels
  typedef struct packed {
    logic       bclk;
    logic       ads_n;
    logic [1:0] stb_n;
    logic [1:0] par;
    req_t       req_n;
    addr_t      addr_n;
  } link_sample_t;

  // ------------------------------------------------------------------
  // parity line levels for one subphase, {line_b, line_a}
  // ------------------------------------------------------------------
  function automatic logic [1:0] cover_parity(input addr_t a,
                                              input req_t  r,
                                              input logic  sub2);
    logic hi_p;
    logic lo_p;
    hi_p = ~^a[`ADDR_MSB:`HI_PAR_LSB];
    lo_p = ~^{a[`LO_PAR_MSB:`ADDR_LSB], r};
    return sub2 ? {hi_p, lo_p} : {lo_p, hi_p};
  endfunction

endpackage

// ==== req_phase_if.sv ====
// Purpose: request-phase pins shared by the requester and receiver ends
// Assumes: every line is pulled high when nobody drives it
// Notes:   the wire level is worked out here from the output enables
`timescale 1ns/1ps
`default_nettype none
`include "fsb_req_params.svh"

interface req_phase_if;

  // ------------------------------------------------------------------
  // bus clock (true half) and resolved wires
  // ------------------------------------------------------------------
  logic                bus_clk;
  fsb_req_pkg::addr_t  addr_lines_n;
  fsb_req_pkg::req_t   req_lines_n;
  logic                address_valid_strobe_n;
  logic [1:0]          address_capture_strobes_n;
  logic [1:0]          address_parity_lines;

  // ------------------------------------------------------------------
  // requester drive
  // ------------------------------------------------------------------
  fsb_req_pkg::addr_t  dev_addr_o;
  fsb_req_pkg::req_t   dev_req_o;
  logic                dev_ads_o;
  logic [1:0]          dev_stb_o;
  logic [1:0]          dev_par_o;
  logic                dev_oe;

  // ------------------------------------------------------------------
  // receiver drive
  // ------------------------------------------------------------------
  fsb_req_pkg::addr_t  rcv_addr_o;
  fsb_req_pkg::req_t   rcv_req_o;
  logic                rcv_ads_o;
  logic [1:0]          rcv_stb_o;
  logic [1:0]          rcv_par_o;
  logic                rcv_oe;

  // wired bus with pull-ups
  assign addr_lines_n = dev_oe ? dev_addr_o :
                        (rcv_oe ? rcv_addr_o : `ADDR_IDLE);
  assign req_lines_n  = dev_oe ? dev_req_o :
                        (rcv_oe ? rcv_req_o : `REQ_IDLE);
  assign address_valid_strobe_n = dev_oe ? dev_ads_o :
                                  (rcv_oe ? rcv_ads_o : 1'b1);
  assign address_capture_strobes_n = dev_oe ? dev_stb_o :
                                     (rcv_oe ? rcv_stb_o : `STB_IDLE);
  assign address_parity_lines = dev_oe ? dev_par_o :
                                (rcv_oe ? rcv_par_o : `PAR_IDLE);

  modport requester (
    input  bus_clk, addr_lines_n, req_lines_n, address_valid_strobe_n,
    input  address_capture_strobes_n, address_parity_lines,
    output dev_addr_o, dev_req_o, dev_ads_o, dev_stb_o, dev_par_o, dev_oe
  );

  modport receiver (
    input  bus_clk, addr_lines_n, req_lines_n, address_valid_strobe_n,
    input  address_capture_strobes_n, address_parity_lines,
    output rcv_addr_o, rcv_req_o, rcv_ads_o, rcv_stb_o, rcv_par_o, rcv_oe
  );

endinterface

`default_nettype wire

// ==== fsb_requester_end.sv ====
// Purpose: requesting agent of the processor_system_bus request phase
// Assumes: bus_clk is far slower than clk_sys (about 10 cycles a period)
// Notes:   one request held at a time; launched on a bus_clk rise
//
// Function
// - subphase 1 address, subphase 2 type info
// - low group strobe 0, high group strobe 1
// - lines source-synchronous, latched on strobes, parity-protected
// - bit20 mask forces address bit 20 low
// - address_valid_strobe marks a valid new transaction
// - agents start checks and decode on strobe
// - parity high when even number covered low
// - parity coverage per subphase, roles swap
// - bus clock drives outputs, latches common inputs
// - timing taken from true bus clock rise
`timescale 1ns/1ps
`default_nettype none
`include "fsb_req_params.svh"

module fsb_requester_end (
  // system clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // bus pins
  req_phase_if.requester           bus,
  // request from the core
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire fsb_req_pkg::addr_t  req_addr,
  input  wire fsb_req_pkg::req_t   req_type,
  input  wire fsb_req_pkg::addr_t  req_info_addr,
  input  wire fsb_req_pkg::req_t   req_info_type,
  // real-mode mask, asynchronous
  input  wire logic                bit20_mask_input,
  // masked address toward the cache lookup
  output fsb_req_pkg::addr_t       lookup_addr,
  output logic                     lookup_valid,
  // phase activity
  output logic                     phase_busy
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [2:0]                 bclk_sync_reg;
  logic [1:0]                 mask_sync_reg;
  logic                       bclk_rise;
  logic                       bclk_fall;
  logic                       take;
  logic                       launch;

  logic                       pend_reg;
  logic                       req_ready_reg;
  fsb_req_pkg::addr_t         hold_addr_reg;
  fsb_req_pkg::req_t          hold_type_reg;
  fsb_req_pkg::addr_t         hold_info_addr_reg;
  fsb_req_pkg::req_t          hold_info_type_reg;
  fsb_req_pkg::addr_t         lookup_addr_reg;
  logic                       lookup_valid_reg;

  fsb_req_pkg::phase_state_t  state_reg;
  logic [2:0]                 cnt_reg;
  fsb_req_pkg::addr_t         addr_o_reg;
  fsb_req_pkg::req_t          req_o_reg;
  logic                       ads_o_reg;
  logic [1:0]                 stb_o_reg;
  logic [1:0]                 par_o_reg;
  logic                       oe_reg;
  logic                       busy_reg;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // clears address bit 20 while the mask is on
  function automatic fsb_req_pkg::addr_t mask_bit20(
      input fsb_req_pkg::addr_t a, input logic on);
    fsb_req_pkg::addr_t r;
    r = a;
    if (on) begin
      r[`BIT20_POS] = 1'b0;
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  // bus clock sampled by clk_sys, third stage only for edge finding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bclk_sync_reg <= 3'h0;
    end else begin
      bclk_sync_reg <= {bclk_sync_reg[1:0], bus.bus_clk};
    end
  end

  // asynchronous mask pin, two flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_sync_reg <= 2'h0;
    end else begin
      mask_sync_reg <= {mask_sync_reg[0], bit20_mask_input};
    end
  end

  // only the true-half rise times the phase, the fall splits subphases
  assign bclk_rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];
  assign bclk_fall = ~bclk_sync_reg[1] & bclk_sync_reg[2];

  assign take   = req_valid & req_ready_reg;
  assign launch = bclk_rise & pend_reg;

  // ------------------------------------------------------------------
  // request holding and cache lookup address
  // ------------------------------------------------------------------
  // the masked address feeds both the lookup and the bus drive
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg           <= 1'b0;
      req_ready_reg      <= 1'b0;
      hold_addr_reg      <= '0;
      hold_type_reg      <= '0;
      hold_info_addr_reg <= '0;
      hold_info_type_reg <= '0;
      lookup_addr_reg    <= '0;
      lookup_valid_reg   <= 1'b0;
    end else if (take) begin
      pend_reg           <= 1'b1;
      req_ready_reg      <= 1'b0;
      hold_addr_reg      <= mask_bit20(req_addr, mask_sync_reg[1]);
      hold_type_reg      <= req_type;
      hold_info_addr_reg <= req_info_addr;
      hold_info_type_reg <= req_info_type;
      lookup_addr_reg    <= mask_bit20(req_addr, mask_sync_reg[1]);
      lookup_valid_reg   <= 1'b1;
    end else begin
      lookup_valid_reg <= 1'b0;
      if (launch) begin
        pend_reg      <= 1'b0;
        req_ready_reg <= 1'b1;
      end else if (!pend_reg) begin
        req_ready_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // request phase drive
  // ------------------------------------------------------------------
  // strobe edges sit STB_DLY_CYC plus one clk_sys cycle after each data change, mid-eye
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= fsb_req_pkg::PH_IDLE;
      cnt_reg    <= 3'h0;
      addr_o_reg <= `ADDR_IDLE;
      req_o_reg  <= `REQ_IDLE;
      ads_o_reg  <= 1'b1;
      stb_o_reg  <= `STB_IDLE;
      par_o_reg  <= `PAR_IDLE;
      oe_reg     <= 1'b0;
    end else if (launch) begin
      // subphase 1: address and request lines, address valid strobe asserted
      state_reg  <= fsb_req_pkg::PH_SUB1;
      cnt_reg    <= 3'h0;
      addr_o_reg <= ~hold_addr_reg;
      req_o_reg  <= ~hold_type_reg;
      ads_o_reg  <= 1'b0;
      stb_o_reg  <= `STB_IDLE;
      par_o_reg  <= fsb_req_pkg::cover_parity(hold_addr_reg,
                      hold_type_reg, 1'b0);
      oe_reg     <= 1'b1;
    end else if (bclk_rise && state_reg != fsb_req_pkg::PH_IDLE) begin
      // one bus clock is over: drop the strobe and release the lines
      state_reg  <= fsb_req_pkg::PH_IDLE;
      addr_o_reg <= `ADDR_IDLE;
      req_o_reg  <= `REQ_IDLE;
      ads_o_reg  <= 1'b1;
      stb_o_reg  <= `STB_IDLE;
      par_o_reg  <= `PAR_IDLE;
      oe_reg     <= 1'b0;
    end else begin
      case (state_reg)
        fsb_req_pkg::PH_SUB1: begin
          if (bclk_fall) begin
            // subphase 2: transaction type information
            state_reg  <= fsb_req_pkg::PH_SUB2;
            cnt_reg    <= 3'h0;
            addr_o_reg <= ~hold_info_addr_reg;
            req_o_reg  <= ~hold_info_type_reg;
            par_o_reg  <= fsb_req_pkg::cover_parity(hold_info_addr_reg,
                            hold_info_type_reg, 1'b1);
          end else if (cnt_reg == 3'(`STB_DLY_CYC)) begin
            stb_o_reg <= `STB_ACTIVE;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        fsb_req_pkg::PH_SUB2: begin
          if (cnt_reg == 3'(`STB_DLY_CYC)) begin
            stb_o_reg <= `STB_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: begin
          cnt_reg <= 3'h0;
        end
      endcase
    end
  end

  // busy from request acceptance until the phase is released
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg != fsb_req_pkg::PH_IDLE) | pend_reg;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign req_ready      = req_ready_reg;
  assign lookup_addr    = lookup_addr_reg;
  assign lookup_valid   = lookup_valid_reg;
  assign phase_busy     = busy_reg;
  assign bus.dev_addr_o = addr_o_reg;
  assign bus.dev_req_o  = req_o_reg;
  assign bus.dev_ads_o  = ads_o_reg;
  assign bus.dev_stb_o  = stb_o_reg;
  assign bus.dev_par_o  = par_o_reg;
  assign bus.dev_oe     = oe_reg;

endmodule

`default_nettype wire

// ==== fsb_receiver_end.sv ====
// Purpose: observing agent (host bridge side) of the request phase
// Assumes: one requester; this end never drives the request lines
// Notes:   presented once the phase ended and both halves are latched
`timescale 1ns/1ps
`default_nettype none
`include "fsb_req_params.svh"

module fsb_receiver_end (
  // system clock and reset
  input  wire logic           clk_sys,
  input  wire logic           arst_n,
  // bus pins
  req_phase_if.receiver       bus,
  // received transaction, asserted-high values
  output logic                new_txn_valid,
  output fsb_req_pkg::addr_t  new_txn_addr,
  output fsb_req_pkg::req_t   new_txn_type,
  output fsb_req_pkg::addr_t  new_txn_info_addr,
  output fsb_req_pkg::req_t   new_txn_info_type,
  output logic                new_txn_parity_err
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  fsb_req_pkg::link_sample_t  s1_reg;
  fsb_req_pkg::link_sample_t  s2_reg;
  logic                       bclk_d_reg;
  logic [1:0]                 stb_d_reg;
  logic [1:0]                 stb_fall;
  logic [1:0]                 stb_rise;
  logic                       bclk_rise;
  fsb_req_pkg::addr_t         sub1_addr_reg;
  fsb_req_pkg::req_t          sub1_req_reg;
  fsb_req_pkg::addr_t         sub2_addr_reg;
  fsb_req_pkg::req_t          sub2_req_reg;
  logic [1:0]                 sub1_par_reg;
  logic [1:0]                 sub2_par_reg;
  logic                       valid_reg;
  fsb_req_pkg::addr_t         addr_reg;
  fsb_req_pkg::req_t          type_reg;
  fsb_req_pkg::addr_t         info_addr_reg;
  fsb_req_pkg::req_t          info_type_reg;
  logic                       perr_reg;
  logic                       ads_seen_reg;
  logic                       sub2_seen_reg;

  // ------------------------------------------------------------------
  // pin synchronisers and edge finders
  // ------------------------------------------------------------------
  // every pin passes two flops; edges are found on the second stage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg     <= '1;
      s2_reg     <= '1;
      bclk_d_reg <= 1'b1;
      stb_d_reg  <= `STB_IDLE;
    end else begin
      s1_reg     <= {bus.bus_clk, bus.address_valid_strobe_n,
                     bus.address_capture_strobes_n,
                     bus.address_parity_lines, bus.req_lines_n,
                     bus.addr_lines_n};
      s2_reg     <= s1_reg;
      bclk_d_reg <= s2_reg.bclk;
      stb_d_reg  <= s2_reg.stb_n;
    end
  end

  assign stb_fall  = ~s2_reg.stb_n & stb_d_reg;
  assign stb_rise  = s2_reg.stb_n & ~stb_d_reg;
  assign bclk_rise = s2_reg.bclk & ~bclk_d_reg;

  // ------------------------------------------------------------------
  // strobe capture: low group on strobe 0, high group on strobe 1
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sub1_addr_reg <= '0;
      sub1_req_reg  <= '0;
      sub2_addr_reg <= '0;
      sub2_req_reg  <= '0;
      sub1_par_reg  <= `PAR_IDLE;
      sub2_par_reg  <= `PAR_IDLE;
    end else begin
      if (stb_fall[0]) begin
        sub1_addr_reg[`LO_GRP_MSB:`ADDR_LSB] <=
          ~s2_reg.addr_n[`LO_GRP_MSB:`ADDR_LSB];
        sub1_req_reg <= ~s2_reg.req_n;
        sub1_par_reg <= s2_reg.par;
      end
      if (stb_fall[1]) begin
        sub1_addr_reg[`ADDR_MSB:`HI_GRP_LSB] <=
          ~s2_reg.addr_n[`ADDR_MSB:`HI_GRP_LSB];
      end
      if (stb_rise[0]) begin
        sub2_addr_reg[`LO_GRP_MSB:`ADDR_LSB] <=
          ~s2_reg.addr_n[`LO_GRP_MSB:`ADDR_LSB];
        sub2_req_reg <= ~s2_reg.req_n;
        sub2_par_reg <= s2_reg.par;
      end
      if (stb_rise[1]) begin
        sub2_addr_reg[`ADDR_MSB:`HI_GRP_LSB] <=
          ~s2_reg.addr_n[`ADDR_MSB:`HI_GRP_LSB];
      end
    end
  end

  // ------------------------------------------------------------------
  // new transaction once address strobe and both subphases are in
  // ------------------------------------------------------------------
  // the subphase 2 strobe edge may trail the closing bus_clk rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ads_seen_reg  <= 1'b0;
      sub2_seen_reg <= 1'b0;
    end else if (ads_seen_reg && sub2_seen_reg) begin
      ads_seen_reg  <= 1'b0;
      sub2_seen_reg <= 1'b0;
    end else begin
      if (bclk_rise && !s2_reg.ads_n) begin
        ads_seen_reg <= 1'b1;
      end
      if (stb_rise[0]) begin
        sub2_seen_reg <= 1'b1;
      end
    end
  end

  // parity and decode start only when the address strobe is seen
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      valid_reg     <= 1'b0;
      addr_reg      <= '0;
      type_reg      <= '0;
      info_addr_reg <= '0;
      info_type_reg <= '0;
      perr_reg      <= 1'b0;
    end else if (ads_seen_reg && sub2_seen_reg) begin
      valid_reg     <= 1'b1;
      addr_reg      <= sub1_addr_reg;
      type_reg      <= sub1_req_reg;
      info_addr_reg <= sub2_addr_reg;
      info_type_reg <= sub2_req_reg;
      perr_reg      <= (sub1_par_reg != fsb_req_pkg::cover_parity(
                          sub1_addr_reg, sub1_req_reg, 1'b0)) |
                       (sub2_par_reg != fsb_req_pkg::cover_parity(
                          sub2_addr_reg, sub2_req_reg, 1'b1));
    end else begin
      valid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // outputs; this end stays off the request lines
  // ------------------------------------------------------------------
  assign new_txn_valid      = valid_reg;
  assign new_txn_addr       = addr_reg;
  assign new_txn_type       = type_reg;
  assign new_txn_info_addr  = info_addr_reg;
  assign new_txn_info_type  = info_type_reg;
  assign new_txn_parity_err = perr_reg;
  assign bus.rcv_addr_o     = `ADDR_IDLE;
  assign bus.rcv_req_o      = `REQ_IDLE;
  assign bus.rcv_ads_o      = 1'b1;
  assign bus.rcv_stb_o      = `STB_IDLE;
  assign bus.rcv_par_o      = `PAR_IDLE;
  assign bus.rcv_oe         = 1'b0;

endmodule

`default_nettype wire

// ==== fsb_request_address_phase_assertions.sv ====
// Purpose: pin-level checks of the request phase link
// Assumes: clk_sys runs about ten times faster than bus_clk
// Notes:   watches the resolved wires only
`timescale 1ns/1ps
`default_nettype none

module fsb_request_address_phase_checker (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               arst_n,
  // link pins
  input wire logic               bus_clk,
  input wire fsb_req_pkg::addr_t addr_lines_n,
  input wire fsb_req_pkg::req_t  req_lines_n,
  input wire logic               address_valid_strobe_n,
  input wire logic [1:0]         address_capture_strobes_n,
  input wire logic [1:0]         address_parity_lines
);
  logic hi_par;
  logic lo_par;

  // --------------------------------------------------------------------
  // expected parity: high when an even count of covered lines is low
  // --------------------------------------------------------------------
  assign hi_par = ~^(~addr_lines_n[35:24]);
  assign lo_par = ~^(~{addr_lines_n[23:3], req_lines_n});

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  ads_one_clk_a: assert property (
    $fell(address_valid_strobe_n) |-> (!address_valid_strobe_n)[*8]
    ##[2:3] address_valid_strobe_n) else $error("ads width wrong");
  stb_follow_a: assert property (
    $fell(address_valid_strobe_n) |-> ##[2:4]
    ($fell(address_capture_strobes_n[0]) &&
     $fell(address_capture_strobes_n[1]))) else $error("strobes late");
  par_sub_one_a: assert property (
    $fell(address_capture_strobes_n[0]) |->
    address_parity_lines == {lo_par, hi_par}) else $error("sub1 parity");
  par_sub_two_a: assert property (
    $rose(address_capture_strobes_n[0]) |->
    address_parity_lines == {hi_par, lo_par}) else $error("sub2 parity");
  stb_in_phase_a: assert property (
    $fell(address_capture_strobes_n[0]) |-> !address_valid_strobe_n)
    else $error("strobe outside phase");
  sub_two_end_a: assert property (
    $rose(address_capture_strobes_n[0]) |-> ##[1:10]
    $rose(address_valid_strobe_n)) else $error("phase not closed");
  lines_release_a: assert property (
    $rose(address_valid_strobe_n) |->
    (addr_lines_n == '1 && req_lines_n == '1)) else $error("not released");
  bclk_ref_a: assert property (
    $fell(address_valid_strobe_n) |-> $past(bus_clk, 3))
    else $error("ads not after bus clock rise");
endmodule

`default_nettype wire

// ==== test_fsb_request_address_phase.sv ====
// Purpose: drives requester, judges receiver and the wires
// Assumes: both ends joined by one req_phase_if
// Notes:   inputs change on the falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none

module test_fsb_request_address_phase;
  logic               clk_sys, arst_n, req_valid, req_ready, mask;
  logic               lookup_valid, phase_busy, new_txn_valid, par_err;
  fsb_req_pkg::addr_t req_addr, req_info_addr, lookup_addr;
  fsb_req_pkg::addr_t new_txn_addr, new_txn_info_addr;
  fsb_req_pkg::req_t  req_type, req_info_type;
  fsb_req_pkg::req_t  new_txn_type, new_txn_info_type;
  int                 error_cnt, checked, ads_cnt;

  req_phase_if req_phase_if_i ();

  fsb_requester_end fsb_requester_end_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .bus(req_phase_if_i), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_type(req_type),
    .req_info_addr(req_info_addr), .req_info_type(req_info_type),
    .bit20_mask_input(mask), .lookup_addr(lookup_addr),
    .lookup_valid(lookup_valid), .phase_busy(phase_busy));
  fsb_receiver_end fsb_receiver_end_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .bus(req_phase_if_i),
    .new_txn_valid(new_txn_valid), .new_txn_addr(new_txn_addr),
    .new_txn_type(new_txn_type), .new_txn_info_addr(new_txn_info_addr),
    .new_txn_info_type(new_txn_info_type), .new_txn_parity_err(par_err));
  fsb_request_address_phase_checker fsb_request_address_phase_checker_i (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .bus_clk(req_phase_if_i.bus_clk),
    .addr_lines_n(req_phase_if_i.addr_lines_n),
    .req_lines_n(req_phase_if_i.req_lines_n),
    .address_valid_strobe_n(req_phase_if_i.address_valid_strobe_n),
    .address_capture_strobes_n(req_phase_if_i.address_capture_strobes_n),
    .address_parity_lines(req_phase_if_i.address_parity_lines));

  // --------------------------------------------------------------------
  // clocks: system 5 ns, bus 48 ns with an offset phase
  // --------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    req_phase_if_i.bus_clk = 1'b0;
    #3;
    forever #24 req_phase_if_i.bus_clk = ~req_phase_if_i.bus_clk;
  end

  // counts phases started on the wire
  always @(negedge req_phase_if_i.address_valid_strobe_n) begin
    if (arst_n === 1'b1) ads_cnt++;
  end

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one transfer end to end, m is the real-mode mask
  task automatic do_req(input fsb_req_pkg::addr_t a,
                        input fsb_req_pkg::req_t  t,
                        input fsb_req_pkg::addr_t ia,
                        input fsb_req_pkg::req_t  it, input logic m);
    fsb_req_pkg::addr_t ea;
    int                 n;
    ea = a;
    if (m) ea[20] = 1'b0;
    @(negedge clk_sys);
    mask = m;
    repeat (4) @(negedge clk_sys);
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= 200, 1'b0);
    req_valid = 1'b1;
    req_addr = a;
    req_type = t;
    req_info_addr = ia;
    req_info_type = it;
    @(negedge clk_sys);
    req_valid = 1'b0;
    check(lookup_valid, 1'b1);
    check(lookup_addr, ea);
    n = 0;
    while (req_phase_if_i.address_valid_strobe_n !== 1'b0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= 200, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(req_phase_if_i.addr_lines_n, fsb_req_pkg::addr_t'(~ea));
    check(req_phase_if_i.req_lines_n, fsb_req_pkg::req_t'(~t));
    check(phase_busy, 1'b1);
    n = 0;
    while (new_txn_valid !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= 200, 1'b0);
    check(phase_busy, 1'b0);
    check(new_txn_addr, ea);
    check(new_txn_type, t);
    check(new_txn_info_addr, ia);
    check(new_txn_info_type, it);
    check(par_err, 1'b0);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_plain();
    do_req(33'h0_1234_5678, 5'h0a, 33'h0_0000_0abc, 5'h15, 1'b0);
  endtask

  // all lines low then all high, parity boundary cases
  task automatic t_extremes();
    do_req('0, '0, '1, '1, 1'b0);
    do_req('1, '1, '0, '0, 1'b0);
  endtask

  // mask clears bit 20, then is lifted again
  task automatic t_mask();
    do_req('1, 5'h03, '1, 5'h1c, 1'b1);
    do_req('1, 5'h03, '1, 5'h1c, 1'b0);
  endtask

  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_addr = '0;
    req_type = '0;
    req_info_addr = '0;
    req_info_type = '0;
    mask = 1'b0;
    error_cnt = 0;
    checked = 0;
    ads_cnt = 0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_plain();
    t_extremes();
    t_mask();
    check(ads_cnt, 64'h5);
    complete_run();
  end

  // watchdog: five transfers need about half a microsecond
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule

`default_nettype wire
